// ===== bench/csf_core_model.sv
// Execution core model: one ALU operation per call.
// Drives on the falling edge of MCLK; idles with no flag updates.
`timescale 1ns/1ps
`default_nettype none
module csf_core_model
	import csf_pkg::*;
(
	input wire logic MCLK,
	output logic [5:0] ALU_OP,
	output logic [7:0] OPERAND_A, OPERAND_B, LOGIC_RESULT,
	output logic UPD_ZERO, UPD_NIBBLE_CARRY, UPD_CARRY
);
	logic [24:0] drv = {OP_NONE, 19'h0};
	assign {ALU_OP, OPERAND_A, OPERAND_B, UPD_ZERO, UPD_NIBBLE_CARRY, UPD_CARRY} = drv;
	// Logic unit modelled as AND
	assign LOGIC_RESULT = OPERAND_A & OPERAND_B;
	task automatic issue(input logic [24:0] t);
		begin
			@(negedge MCLK);
			drv = t;
			@(negedge MCLK);
			// Operands invert when idle so stale values cannot pass
			drv = {OP_NONE, ~t[18:3], 3'h0};
		end
	endtask
endmodule
`default_nettype wire

// ===== bench/csf_status_reg_properties.sv
// Port checker for csf_status_reg.
// Bound to every instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module csf_status_reg_properties
	import csf_pkg::*;
(
	input wire logic MCLK, RST, UPD_CARRY, WR_EN,
	input wire logic WATCHDOG_TIMEOUT, WATCHDOG_CLEAR_INSTR, SLEEP_INSTR,
	input wire logic [5:0] ALU_OP,
	input wire logic [6:0] DIRECT_ADDR,
	input wire logic [7:0] OPERAND_A, OPERAND_B, WR_DATA, INDIRECT_PTR, STATUS_Q, ALU_RESULT,
	input wire logic [8:0] WR_ADDR, DIRECT_MEM_ADDR, INDIRECT_MEM_ADDR
);
	// Past values are only trusted one cycle clear of reset
	logic live_r;
	always_ff @(posedge MCLK)
		live_r <= !RST;
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	a_ind_bank: assert property (
		live_r |-> INDIRECT_MEM_ADDR == {$past(STATUS_Q[7]), $past(INDIRECT_PTR)}) else $error("ind");
	a_dir_bank: assert property (
		live_r |-> DIRECT_MEM_ADDR == {$past(STATUS_Q[6:5]), $past(DIRECT_ADDR)}) else $error("dir");
	a_expiry_clear: assert property (
		live_r && $past(WATCHDOG_TIMEOUT) |-> !STATUS_Q[4]) else $error("expiry");
	a_cause_held: assert property (
		live_r && !$past(WATCHDOG_TIMEOUT || WATCHDOG_CLEAR_INSTR || SLEEP_INSTR)
		|-> $stable(STATUS_Q[4:3])) else $error("cause bits");
	a_bank_write: assert property (
		live_r && $past(WR_EN && WR_ADDR[6:0] == STATUS_ADDR_OFFS)
		|-> STATUS_Q[7:5] == $past(WR_DATA[7:5])) else $error("bank write");
	a_sub_borrow: assert property (
		ALU_OP == OP_SUB && UPD_CARRY
		|=> STATUS_Q[0] == ($past(OPERAND_A) >= $past(OPERAND_B))) else $error("borrow");
	a_sub_result: assert property (
		ALU_OP == OP_SUB |=> ALU_RESULT == 8'($past(OPERAND_A) - $past(OPERAND_B))) else $error("diff");
	a_rot_carry: assert property (
		UPD_CARRY && ALU_OP == OP_ROT_LEFT |=> STATUS_Q[0] == $past(OPERAND_A[7])) else $error("rot");
endmodule
bind csf_status_reg csf_status_reg_properties i_props (.*);
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for csf_status_reg.
// Core model issues ALU work; bench drives writes, events, addresses.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import csf_pkg::*;
	logic MCLK = 1'b0, RST = 1'b1, WR_EN = 1'b0, WATCHDOG_TIMEOUT = 1'b0;
	logic WATCHDOG_CLEAR_INSTR = 1'b0, SLEEP_INSTR = 1'b0, UPD_ZERO, UPD_NIBBLE_CARRY, UPD_CARRY;
	logic [5:0] ALU_OP;
	logic [6:0] DIRECT_ADDR = 7'h5A;
	logic [7:0] OPERAND_A, OPERAND_B, LOGIC_RESULT, STATUS_Q, ALU_RESULT;
	logic [7:0] WR_DATA = 8'h00, INDIRECT_PTR = 8'hC3;
	logic [8:0] WR_ADDR = 9'h000, DIRECT_MEM_ADDR, INDIRECT_MEM_ADDR;
	logic [24:0] tab [11] = '{{OP_SUB, 16'h0503, 3'h7}, {OP_SUB, 16'h0305, 3'h7},
		{OP_SUB, 16'h1001, 3'h7}, {OP_SUB, 16'h0700, 3'h7}, {OP_ADD, 16'h0808, 3'h7},
		{OP_LOGIC, 16'hF00F, 3'h4}, {OP_LOGIC, 16'hF0F1, 3'h4}, {OP_ROT_LEFT, 16'h8100, 3'h1},
		{OP_ROT_LEFT, 16'h7E00, 3'h1}, {OP_ROT_RIGHT, 16'h0100, 3'h1},
		{OP_ROT_RIGHT, 16'hFE00, 3'h1}};
	int err_total = 0, total_checks = 0;
	always #2.5 MCLK = ~MCLK;
	csf_core_model i_csf_core_model (.*);
	csf_status_reg i_csf_status_reg (.*);
	task automatic chk(input logic [8:0] seen, exp);
		begin
			total_checks++;
			if (seen !== exp)
			begin
				err_total++;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task automatic report_and_stop;
		begin
			if (err_total == 0 && total_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task automatic wr(input logic [8:0] ad, input logic [7:0] d);
		begin
			@(negedge MCLK);
			{WR_EN, WR_ADDR, WR_DATA} = {1'b1, ad, d};
			@(negedge MCLK);
			{WR_EN, WR_DATA} = {1'b0, ~d};
		end
	endtask
	task automatic run(input logic [24:0] t);
		logic [5:0] o;
		logic [7:0] a, b, bb;
		logic [8:0] s;
		logic [4:0] n;
		logic [2:0] f;
		begin
			{o, a, b} = t[24:3];
			// Subtract as add of two's complement
			bb = o == OP_SUB ? ~b : b;
			s = a + bb + (o == OP_SUB);
			n = a[3:0] + bb[3:0] + (o == OP_SUB);
			f[2] = o == OP_LOGIC ? (a & b) == 8'h00 : s[7:0] == 8'h00;
			f[1] = n[4];
			f[0] = o == OP_ROT_LEFT ? a[7] : o == OP_ROT_RIGHT ? a[0] : s[8];
			i_csf_core_model.issue(t);
			chk(9'(STATUS_Q[2:0] & t[2:0]), 9'(f & t[2:0]));
			if (o == OP_ADD || o == OP_SUB)
				chk(9'(ALU_RESULT), 9'(s[7:0]));
		end
	endtask
	initial
	begin
		logic [2:0] evs [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
		logic [1:0] exs [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
		repeat (20) @(negedge MCLK);
		chk(9'(STATUS_Q), 9'(STATUS_RESET));
		RST = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			wr({k[1:0], 7'h03}, {k[2:0], 5'h00});
			chk(9'(STATUS_Q), {1'b0, k[2:0], 5'h18});
			{DIRECT_ADDR, INDIRECT_PTR} = {k[2:0], ~k[3:0], k[3:0], ~k[3:0]};
			@(negedge MCLK);
			chk(DIRECT_MEM_ADDR, {k[1:0], DIRECT_ADDR});
			chk(INDIRECT_MEM_ADDR, {k[2], INDIRECT_PTR});
		end
		fork
			run({OP_ADD, 16'hFF01, 3'h7});
			wr(9'h183, 8'hE0);
		join
		chk(9'(STATUS_Q), 9'h0FF);
		foreach (tab[i])
			run(tab[i]);
		foreach (evs[i])
		begin
			@(negedge MCLK);
			{SLEEP_INSTR, WATCHDOG_CLEAR_INSTR, WATCHDOG_TIMEOUT} = evs[i];
			@(negedge MCLK);
			{SLEEP_INSTR, WATCHDOG_CLEAR_INSTR, WATCHDOG_TIMEOUT} = 3'h0;
			chk(9'(STATUS_Q[4:3]), 9'(exs[i]));
		end
		report_and_stop();
	end
	initial
	begin
		#20000;
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// ===== core/csf_flag_unit.sv
// Flag computation for arithmetic, logic and rotate results.
// Pure combinational; the top registers everything it produces.
`timescale 1ns/1ps
`default_nettype none
module csf_flag_unit
	import csf_pkg::*;
(
	input  wire logic [5:0] op,
	input  wire logic [7:0] operand_a,
	input  wire logic [7:0] operand_b,
	input  wire logic [7:0] logic_result,
	input  wire logic       carry_in,
	output logic [7:0]      result,
	output logic            zero,
	output logic            nibble_carry,
	output logic            carry
);
	logic [7:0] addend;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic       sub_sel;

	// Subtraction adds the two's complement; carries then read as not-borrow
	assign sub_sel = (op == OP_SUB);
	assign addend  = sub_sel ? (~operand_b + 8'h01) : operand_b;
	assign sum     = {1'b0, operand_a} + {1'b0, addend};
	// Low nibble sum for the complemented operand needs the +1 in nibble form
	assign low_sum = sub_sel
		? ({1'b0, operand_a[3:0]} + {1'b0, ~operand_b[3:0]} + 5'h01)
		: ({1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]});

	always_comb
	begin
		result       = logic_result;
		nibble_carry = 1'b0;
		carry        = carry_in;
		unique case (op)
			OP_ADD, OP_SUB:
			begin
				result       = sum[7:0];
				nibble_carry = low_sum[4];
				carry        = sum[8] | (sub_sel & (operand_b == 8'h00));
			end
			OP_ROT_LEFT:
			begin
				result = {operand_a[6:0], carry_in};
				carry  = operand_a[7];
			end
			OP_ROT_RIGHT:
			begin
				result = {carry_in, operand_a[7:1]};
				carry  = operand_a[0];
			end
			default:
			begin
				result       = logic_result;
				nibble_carry = 1'b0;
				carry        = carry_in;
			end
		endcase
	end
	assign zero = (result == 8'h00);
endmodule
`default_nettype wire

// ===== core/csf_status_reg.sv
// Core status register: arithmetic flags, reset-cause flags, bank select.
// Assumes the execution core presents one instruction per MCLK with its
// flag-update strobes, and the watchdog and sleep logic pulse their events
// for one MCLK cycle in the MCLK domain; no input is synchronised here.
// Memory address logic takes the registered bank-qualified addresses.
//
// Behaviour
// - The indirect bank bit picks banks 2-3 when one and banks 0-1 when zero, for indirect access.
// - The two direct bank bits select bank 3, 2, 1 or 0 for direct addressing as coded 11..00.
// - Each bank spans 128 bytes and the direct address gives the low seven bits.
// - For subtraction carry and nibble carry act as not-borrow.
// - Subtraction adds the two's complement; zero comes from that sum, nibble carry from its own nibble sum, and carry is forced to one for a zero subtrahend.
// - Rotates through carry load carry with the bit shifted out.
// - A data write to this register by a flag-updating instruction leaves each flag that the instruction updates to the flag logic.
// - Instruction writes never change the watchdog expiry or sleep entered flags.
`timescale 1ns/1ps
`default_nettype none
module csf_status_reg
	import csf_pkg::*;
(
	input  wire logic       MCLK,
	input  wire logic       RST,
	input  wire logic [5:0] ALU_OP,
	input  wire logic [7:0] OPERAND_A,
	input  wire logic [7:0] OPERAND_B,
	input  wire logic [7:0] LOGIC_RESULT,
	input  wire logic       UPD_ZERO,
	input  wire logic       UPD_NIBBLE_CARRY,
	input  wire logic       UPD_CARRY,
	input  wire logic       WR_EN,
	input  wire logic [8:0] WR_ADDR,
	input  wire logic [7:0] WR_DATA,
	input  wire logic       WATCHDOG_TIMEOUT,
	input  wire logic       WATCHDOG_CLEAR_INSTR,
	input  wire logic       SLEEP_INSTR,
	input  wire logic [6:0] DIRECT_ADDR,
	input  wire logic [7:0] INDIRECT_PTR,
	output logic [7:0]      STATUS_Q,
	output logic [7:0]      ALU_RESULT,
	output logic [8:0]      DIRECT_MEM_ADDR,
	output logic [8:0]      INDIRECT_MEM_ADDR
);
	// Committed register fields
	logic [2:0] bank_r;
	logic       expiry_r;
	logic       sleep_r;
	logic [2:0] flag_r;
	logic [7:0] alu_result_r;
	logic [8:0] direct_addr_r;
	logic [8:0] indirect_addr_r;

	// Flag unit results and decoded write fields
	logic [7:0] fu_result;
	logic       fu_zero;
	logic       fu_nibble;
	logic       fu_carry;
	logic       hit;
	logic [2:0] wr_bank;
	logic [2:0] wr_flags;
	logic [2:0] flag_upd;
	logic [2:0] flag_calc;

	// Reset-cause events
	logic       expiry_set;
	logic       expiry_clr;
	logic       sleep_set;
	logic       sleep_clr;

	// Address formation
	logic [1:0] direct_bank;
	logic       indirect_bank;
	logic [8:0] direct_addr_nxt;
	logic [8:0] indirect_addr_nxt;

	csf_flag_unit u_flags (
		.op           (ALU_OP),
		.operand_a    (OPERAND_A),
		.operand_b    (OPERAND_B),
		.logic_result (LOGIC_RESULT),
		.carry_in     (flag_r[BIT_CARRY]),
		.result       (fu_result),
		.zero         (fu_zero),
		.nibble_carry (fu_nibble),
		.carry        (fu_carry)
	);

	// Register is mirrored in every bank, so only the in-bank offset decodes
	assign hit      = WR_EN & (WR_ADDR[BANK_ADDR_BITS-1:0] == STATUS_ADDR_OFFS);
	assign wr_bank  = WR_DATA[BIT_INDIRECT_BANK:BIT_BANK_LOW];
	assign wr_flags = WR_DATA[BIT_ZERO:BIT_CARRY];

	assign flag_upd[BIT_ZERO]          = UPD_ZERO;
	assign flag_upd[BIT_NIBBLE_CARRY]  = UPD_NIBBLE_CARRY;
	assign flag_upd[BIT_CARRY]         = UPD_CARRY;
	assign flag_calc[BIT_ZERO]         = fu_zero;
	assign flag_calc[BIT_NIBBLE_CARRY] = fu_nibble;
	assign flag_calc[BIT_CARRY]        = fu_carry;

	// Nothing on the data bus reaches the two cause bits
	assign expiry_set = WATCHDOG_CLEAR_INSTR | SLEEP_INSTR;
	assign expiry_clr = WATCHDOG_TIMEOUT;
	assign sleep_set  = WATCHDOG_CLEAR_INSTR;
	assign sleep_clr  = SLEEP_INSTR;

	// Each bank spans 128 bytes; the instruction supplies the low seven bits
	assign direct_bank       = bank_r[1:0];
	assign indirect_bank     = bank_r[2];
	assign direct_addr_nxt   = {direct_bank, DIRECT_ADDR};
	assign indirect_addr_nxt = {indirect_bank, INDIRECT_PTR};

	// Bank bits 7:5 are taken from a data write, as are flag bits 2:0
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			bank_r <= STATUS_RESET[BIT_INDIRECT_BANK:BIT_BANK_LOW];
		end
		else if (hit)
		begin
			bank_r <= wr_bank;
		end
	end

	// Time-out beats a same-cycle clear-watchdog so the event is not lost
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			expiry_r <= STATUS_RESET[BIT_WDOG_EXPIRY];
		end
		else if (expiry_clr)
		begin
			expiry_r <= 1'b0;
		end
		else if (expiry_set)
		begin
			expiry_r <= 1'b1;
		end
	end

	// Sleep wins over a same-cycle clear-watchdog
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			sleep_r <= STATUS_RESET[BIT_SLEEP_ENTERED];
		end
		else if (sleep_clr)
		begin
			sleep_r <= 1'b0;
		end
		else if (sleep_set)
		begin
			sleep_r <= 1'b1;
		end
	end

	// Flags come up cleared, a choice: code must not rely on that state
	// Flag logic outranks a data write to the same bit
	for (genvar g = BIT_CARRY; g <= BIT_ZERO; g++)
	begin : g_flag
		always_ff @(posedge MCLK)
		begin
			if (RST)
			begin
				flag_r[g] <= STATUS_RESET[g];
			end
			else if (flag_upd[g])
			begin
				flag_r[g] <= flag_calc[g];
			end
			else if (hit)
			begin
				flag_r[g] <= wr_flags[g];
			end
		end
	end

	// Result registered every cycle; meaningful only for an issued op
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			alu_result_r <= 8'h00;
		end
		else
		begin
			alu_result_r <= fu_result;
		end
	end

	// Addresses use the committed bank bits; a bank change lands next cycle
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			direct_addr_r <= 9'h0_000;
		end
		else
		begin
			direct_addr_r <= direct_addr_nxt;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			indirect_addr_r <= 9'h0_000;
		end
		else
		begin
			indirect_addr_r <= indirect_addr_nxt;
		end
	end

	assign STATUS_Q          = {bank_r, expiry_r, sleep_r, flag_r};
	assign ALU_RESULT        = alu_result_r;
	assign DIRECT_MEM_ADDR   = direct_addr_r;
	assign INDIRECT_MEM_ADDR = indirect_addr_r;
endmodule
`default_nettype wire

// ===== include/csf_pkg.sv
// Package for the core status flags and bank select register.
// Shared by the status register top and its flag computation unit.
`default_nettype none
package csf_pkg;
	localparam logic [8:0] STATUS_ADDR_LOW   = 9'h0_003;
	localparam logic [6:0] STATUS_ADDR_OFFS  = 7'h03;
	localparam int         BIT_INDIRECT_BANK = 7;
	localparam int         BIT_BANK_HIGH     = 6;
	localparam int         BIT_BANK_LOW      = 5;
	localparam int         BIT_WDOG_EXPIRY   = 4;
	localparam int         BIT_SLEEP_ENTERED = 3;
	localparam int         BIT_ZERO          = 2;
	localparam int         BIT_NIBBLE_CARRY  = 1;
	localparam int         BIT_CARRY         = 0;
	localparam int         BANK_SPAN         = 128;
	localparam int         BANK_ADDR_BITS    = 7;
	localparam logic [7:0] STATUS_RESET      = 8'h18;
	localparam logic [7:0] WRITABLE_MASK     = 8'hE7;
	localparam logic [7:0] FLAG_MASK         = 8'h07;
	localparam logic [3:0] NIBBLE_ONES       = 4'hF;

	typedef enum logic [5:0] {
		OP_NONE      = 6'b00_0001,
		OP_ADD       = 6'b00_0010,
		OP_SUB       = 6'b00_0100,
		OP_LOGIC     = 6'b00_1000,
		OP_ROT_LEFT  = 6'b01_0000,
		OP_ROT_RIGHT = 6'b10_0000
	} csf_op_t;
endpackage
`default_nettype wire
